// ### design/sfs_pkg.sv
/*
 Package for the frame status queue: register offsets, field positions,
 reset values and sizes shared by the design and its bench.
 Assumes a classic Wishbone slave with 32-bit data, one register a word.
*/
package sfs_pkg;
   // byte offsets of the register words
   localparam logic [7:0] SFS_ADDR_EXT_STATUS    = 8'h00;
   localparam logic [7:0] SFS_ADDR_RX_COND       = 8'h04;
   localparam logic [7:0] SFS_ADDR_VECTOR        = 8'h08;
   localparam logic [7:0] SFS_ADDR_PENDING       = 8'h0c;
   localparam logic [7:0] SFS_ADDR_EXT_IMAGE     = 8'h10;
   localparam logic [7:0] SFS_ADDR_RX_COND_IMAGE = 8'h14;
   localparam logic [7:0] SFS_ADDR_CNT_LOW       = 8'h18;
   localparam logic [7:0] SFS_ADDR_CNT_HIGH      = 8'h1c;
   localparam logic [7:0] SFS_ADDR_FEATURE       = 8'h3c;
   localparam logic [7:0] SFS_ADDR_INT_MODE      = 8'h40;
   localparam logic [7:0] SFS_ADDR_COMMAND       = 8'h44;
   // field positions
   localparam int SFS_FEAT_EN_BIT   = 2;
   localparam int SFS_AVAIL_BIT     = 6;
   localparam int SFS_OVFL_BIT      = 7;
   localparam int SFS_MODE_LO_BIT   = 3;
   localparam int SFS_MODE_HI_BIT   = 4;
   localparam int SFS_RES_LSB       = 1;
   localparam int SFS_OVR_BIT       = 5;
   localparam int SFS_CRC_BIT       = 6;
   localparam int SFS_EOF_BIT       = 7;
   localparam int SFS_SENT_BIT      = 0;
   localparam int SFS_PAR_BIT       = 4;
   localparam int SFS_CMD_ERR_BIT   = 0;
   localparam int SFS_CMD_IUS_BIT   = 1;
   // sizes
   localparam int SFS_DEPTH         = 10;
   localparam int SFS_CNT_W         = 14;
   localparam int SFS_STAT_W        = 5;
   localparam int SFS_CNT_LOW_W     = 8;
   localparam logic [31:0] SFS_ZERO = 32'h0000_0000;
endpackage : sfs_pkg

// ### design/sfs_frame_status_fifo.sv
/*
 Frame status queue for a bit-oriented receiver channel with a classic
 Wishbone register slave. Assumes the receiver supplies single-cycle
 event pulses and live status levels on core_clk.
*/
// Chosen here: the Wishbone slave port and the address map.
//
// Summary of operation
// - ten entries of count plus five status
// - count registers live only when queue enabled
// - closing flag pushes entry, resets crc checker
// - push while ten held is overflow
// - abort pushes count, clears byte counter
// - queue needs enable bit and bit-oriented mode
// - pointers clear when disabled or reset
// - upper four slots mirror lower four
// - readback bit shows queue enable
// - reads give head; condition read pops
// - empty queue gives live condition status
// - data-available bit set when not empty
// - only residue, overrun, crc are queued
// - empty condition read never underflows
// - high read latches available, steers mux
// - frame end advances write pointer
// - push while full sets overflow flag
// - overflow clears on enable off then on
// - anti-lock: frame-end char raises data vector
// - overrun or parity locks until error reset
`timescale 1ns/1ps
module sfs_frame_status_fifo
   import sfs_pkg::*;
#(
   parameter int DEPTH = SFS_DEPTH,
   parameter int CNT_W = SFS_CNT_W
)(
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   input  wire logic        clkEn,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        bitSyncMode,
   input  wire logic        rxByteDone,
   input  wire logic        frameEnd,
   input  wire logic        frameAbort,
   input  wire logic [2:0]  rxResidue,
   input  wire logic        rxOverrun,
   input  wire logic        rxCrcError,
   input  wire logic        rxAllSent,
   input  wire logic        rxParity,
   input  wire logic        rxEndOfFrame,
   input  wire logic [7:0]  extStatus,
   input  wire logic [7:0]  vectorValue,
   input  wire logic [7:0]  pendingValue,
   input  wire logic        headCharEof,
   input  wire logic        headCharErr,
   input  wire logic        headCharRead,
   output logic             crcReset,
   output logic             rxDataVectorIrq,
   output logic             specialRxIrq,
   output logic             rxFifoLocked,
   output logic             topServiceClear
);
   // the level counts up to DEPTH, so it is sized for DEPTH + 1 values to show full
   localparam int ENT_W = CNT_W + SFS_STAT_W;
   localparam int PTR_W = $clog2(DEPTH);
   localparam int LVL_W = $clog2(DEPTH + 1);
   localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
   localparam logic [LVL_W-1:0] LVL_FULL = LVL_W'(DEPTH);
   // entry layout: byte count on top, then residue, overrun, crc error
   localparam int ENT_CRC = 0;
   localparam int ENT_OVR = 1;
   localparam int ENT_RES = 2;
   localparam int ENT_CNT = SFS_STAT_W;

   //------------------------------------------------------------
   // storage and control state
   //------------------------------------------------------------
   // one word per frame, so the host can check frames long after
   logic [ENT_W-1:0] entryMem [DEPTH];
   logic [PTR_W-1:0] wrPtr_reg;
   logic [PTR_W-1:0] rdPtr_reg;
   logic [LVL_W-1:0] level_reg;
   logic [CNT_W-1:0] byteCnt_reg;
   logic             featEn_reg;
   logic [1:0]       intMode_reg;
   logic             ovfl_reg;
   logic             useLive_reg;
   logic             lockErr_reg;

   logic             qActive;
   logic             qEmpty;
   logic             qFull;
   logic             push;
   logic             pop;
   logic             pushOk;
   logic             lockSet;
   logic             busReq;
   logic             rdReq;
   logic             wrReq;
   logic [ENT_W-1:0] headEntry;
   logic [7:0]       liveCond;
   logic [7:0]       condView;
   logic [7:0]       cntLowView;
   logic [7:0]       cntHighView;
   logic [7:0]       featView;
   logic [31:0]      rdData_next;
   logic             antiLock;

   //------------------------------------------------------------
   // queue status
   //------------------------------------------------------------
   // the queue only runs in bit-oriented mode with the enable set
   assign qActive   = featEn_reg & bitSyncMode;
   assign qEmpty    = (level_reg == '0);
   assign qFull     = (level_reg == LVL_FULL);
   assign push      = clkEn & qActive & (frameEnd | frameAbort);
   // a push into a full queue is dropped and only raises the overflow
   assign pushOk    = push & ~qFull;
   // masking the ack cycle makes a held request count only once
   assign busReq    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign rdReq     = clkEn & busReq & ~wb_we_i;
   assign wrReq     = clkEn & busReq & wb_we_i;
   // an empty queue is never popped, so repeated reads are harmless
   assign pop       = rdReq & (wb_adr_i == SFS_ADDR_RX_COND
                      | wb_adr_i == SFS_ADDR_RX_COND_IMAGE)
                      & qActive & ~qEmpty & ~useLive_reg;
   assign headEntry = entryMem[rdPtr_reg];
   assign antiLock  = qActive & intMode_reg[1] & intMode_reg[0];
   // outside the anti-lock mode a frame-end character locks the data
   // path as well, until software issues the error reset
   assign lockSet   = headCharRead
                      & (headCharErr | (headCharEof & ~antiLock));

   //------------------------------------------------------------
   // byte counter
   //------------------------------------------------------------
   // counts data bytes of the open frame; restarts after each push
   // a byte pulse in the closing cycle is lost along with that frame;
   // the count wraps at its width, so very long frames report modulo
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         byteCnt_reg <= '0;
      end else if (clkEn) begin
         if (frameEnd | frameAbort) begin
            byteCnt_reg <= '0;
         end else if (rxByteDone) begin
            byteCnt_reg <= byteCnt_reg + 1'b1;
         end
      end
   end

   //------------------------------------------------------------
   // entry storage
   //------------------------------------------------------------
   // a push into a full queue writes nothing, keeping older frames;
   // the memory has no reset since level_reg says which words count
   always_ff @(posedge core_clk) begin
      if (pushOk) begin
         entryMem[wrPtr_reg] <= {byteCnt_reg, rxResidue,
                                 rxOverrun, rxCrcError};
      end
   end

   //------------------------------------------------------------
   // pointers and level
   //------------------------------------------------------------
   // a disabled queue forgets its contents; clearing under clkEn keeps
   // the whole block frozen while the enable is low
   // the depth need not be a power of two, so pointers wrap by compare
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
         level_reg <= '0;
      end else if (clkEn) begin
         if (!qActive) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            level_reg <= '0;
         end else begin
            if (pushOk) begin
               wrPtr_reg <= (wrPtr_reg == PTR_LAST) ? '0 : wrPtr_reg + 1'b1;
            end
            if (pop) begin
               rdPtr_reg <= (rdPtr_reg == PTR_LAST) ? '0 : rdPtr_reg + 1'b1;
            end
            // a pop and a push in one cycle leave the level as it is
            if (pushOk & ~pop) begin
               level_reg <= level_reg + 1'b1;
            end else if (pop & ~pushOk) begin
               level_reg <= level_reg - 1'b1;
            end
         end
      end
   end

   //------------------------------------------------------------
   // overflow flag
   //------------------------------------------------------------
   // only reset or an enable cycle clears it; bus reads leave it alone
   // a dropped push is the only event that sets it
   always_ff @(posedge core_clk) begin
      if (sys_rst || !featEn_reg) begin
         ovfl_reg <= 1'b0;
      end else if (push & qFull) begin
         ovfl_reg <= 1'b1;
      end
   end

   //------------------------------------------------------------
   // high-count read latch and mux steering
   //------------------------------------------------------------
   // the latch freezes the view so a push between the high read and
   // the condition read cannot make the popped status mismatch
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         useLive_reg <= 1'b0;
      end else if (clkEn) begin
         if (!qActive) begin
            useLive_reg <= 1'b0;
         end else if (rdReq && wb_adr_i == SFS_ADDR_CNT_HIGH) begin
            // holds the empty state that this high read reported
            useLive_reg <= qEmpty;
         end else if (rdReq && (wb_adr_i == SFS_ADDR_RX_COND
                      || wb_adr_i == SFS_ADDR_RX_COND_IMAGE)) begin
            useLive_reg <= 1'b0;
         end
      end
   end

   //------------------------------------------------------------
   // control registers
   //------------------------------------------------------------
   // every field sits in byte lane 0, so other lanes write nothing;
   // writing the enable to 0 is also how software clears the overflow
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         featEn_reg  <= 1'b0;
         intMode_reg <= 2'h0;
      end else if (wrReq && wb_sel_i[0]) begin
         if (wb_adr_i == SFS_ADDR_FEATURE) begin
            featEn_reg <= wb_dat_i[SFS_FEAT_EN_BIT];
         end else if (wb_adr_i == SFS_ADDR_INT_MODE) begin
            intMode_reg <= {wb_dat_i[SFS_MODE_HI_BIT],
                            wb_dat_i[SFS_MODE_LO_BIT]};
         end
      end
   end

   //------------------------------------------------------------
   // receive data lock and interrupt pulses
   //------------------------------------------------------------
   // a locking character wins over a same-cycle error reset; the lock
   // then holds until software issues the error reset
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         lockErr_reg <= 1'b0;
      end else if (clkEn) begin
         if (lockSet) begin
            lockErr_reg <= 1'b1;
         end else if (wrReq && wb_sel_i[0]
                      && wb_adr_i == SFS_ADDR_COMMAND
                      && wb_dat_i[SFS_CMD_ERR_BIT]) begin
            lockErr_reg <= 1'b0;
         end
      end
   end

   // every output is registered so the host never sees a glitch
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rxDataVectorIrq <= 1'b0;
         specialRxIrq    <= 1'b0;
         rxFifoLocked    <= 1'b0;
         topServiceClear <= 1'b0;
         crcReset        <= 1'b0;
      end else if (clkEn) begin
         // in anti-lock mode a frame-end char at head gives the data vector, no lock
         rxDataVectorIrq <= antiLock & headCharEof & ~headCharErr;
         specialRxIrq    <= headCharRead & headCharErr;
         rxFifoLocked    <= lockErr_reg | lockSet;
         topServiceClear <= wrReq && wb_sel_i[0]
                            && wb_adr_i == SFS_ADDR_COMMAND
                            && wb_dat_i[SFS_CMD_IUS_BIT];
         // only a closing flag restarts the checker; an abort hunts anyway
         crcReset        <= frameEnd;
      end
   end

   //------------------------------------------------------------
   // read views
   //------------------------------------------------------------
   // live condition image; the bypass bits always come from here
   always_comb begin
      liveCond = 8'h00;
      liveCond[SFS_SENT_BIT]                 = rxAllSent;
      liveCond[SFS_PAR_BIT]                  = rxParity;
      liveCond[SFS_EOF_BIT]                  = rxEndOfFrame;
      liveCond[SFS_RES_LSB +: 3]             = rxResidue;
      liveCond[SFS_OVR_BIT]                  = rxOverrun;
      liveCond[SFS_CRC_BIT]                  = rxCrcError;
      condView = liveCond;
      // queued bits come from the head; the rest always bypass
      if (qActive && !qEmpty && !useLive_reg) begin
         condView[SFS_RES_LSB +: 3] = headEntry[ENT_RES +: 3];
         condView[SFS_OVR_BIT]      = headEntry[ENT_OVR];
         condView[SFS_CRC_BIT]      = headEntry[ENT_CRC];
      end
   end

   assign cntLowView  = headEntry[ENT_CNT +: SFS_CNT_LOW_W];
   always_comb begin
      cntHighView = 8'h00;
      cntHighView[CNT_W-SFS_CNT_LOW_W-1:0] =
         headEntry[ENT_W-1 : ENT_CNT+SFS_CNT_LOW_W];
      cntHighView[SFS_AVAIL_BIT] = ~qEmpty;
      cntHighView[SFS_OVFL_BIT]  = ovfl_reg;
      featView = 8'h00;
      featView[SFS_FEAT_EN_BIT] = featEn_reg;
   end

   //------------------------------------------------------------
   // bus read decode
   //------------------------------------------------------------
   // decoded from the held address; rdReq decides if it is taken
   always_comb begin
      rdData_next = SFS_ZERO;
      if (wb_adr_i == SFS_ADDR_EXT_STATUS
          || wb_adr_i == SFS_ADDR_EXT_IMAGE) begin
         rdData_next[7:0] = extStatus;
      end else if (wb_adr_i == SFS_ADDR_RX_COND
                   || wb_adr_i == SFS_ADDR_RX_COND_IMAGE) begin
         rdData_next[7:0] = condView;
      end else if (wb_adr_i == SFS_ADDR_VECTOR) begin
         rdData_next[7:0] = vectorValue;
      end else if (wb_adr_i == SFS_ADDR_PENDING) begin
         rdData_next[7:0] = pendingValue;
      end else if (wb_adr_i == SFS_ADDR_CNT_LOW) begin
         // count slots mirror the lower ones unless the queue runs
         rdData_next[7:0] = qActive ? cntLowView : vectorValue;
      end else if (wb_adr_i == SFS_ADDR_CNT_HIGH) begin
         rdData_next[7:0] = qActive ? cntHighView : pendingValue;
      end else if (wb_adr_i == SFS_ADDR_FEATURE) begin
         rdData_next[7:0] = featView;
      end else if (wb_adr_i == SFS_ADDR_INT_MODE) begin
         // the mode bits read back at the positions they were written
         rdData_next[SFS_MODE_LO_BIT] = intMode_reg[0];
         rdData_next[SFS_MODE_HI_BIT] = intMode_reg[1];
      end
   end

   //------------------------------------------------------------
   // wishbone answer
   //------------------------------------------------------------
   // one-cycle ack; unmapped addresses answer with zero data
   // read data stands until the next read, so a slow master still has it
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= SFS_ZERO;
      end else if (clkEn) begin
         wb_ack_o <= busReq;
         if (rdReq) begin
            wb_dat_o <= rdData_next;
         end
      end
   end
endmodule : sfs_frame_status_fifo

// ### test/sfs_frame_status_fifo_assertions.sv
/*
 Checker for the frame status queue: timing relations at its ports.
 Assumes it is bound to sfs_frame_status_fifo and sees only its ports.
*/
`timescale 1ns/1ps
module sfs_frame_status_fifo_checker
   import sfs_pkg::*;
(
   input wire logic        core_clk,
   input wire logic        sys_rst,
   input wire logic        clkEn,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        frameEnd,
   input wire logic        crcReset,
   input wire logic [7:0]  extStatus,
   input wire logic        rxAllSent,
   input wire logic        rxParity,
   input wire logic        rxEndOfFrame,
   input wire logic        topServiceClear
);
   // -----------------------------------------------------------------
   // enable shadow and shared sequences
   // -----------------------------------------------------------------
   logic enReg;
   // mirrors the enable bit so readback can be tied to the last write
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         enReg <= 1'b0;
      end else if (clkEn && wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i
                   && wb_sel_i[0] && wb_adr_i == SFS_ADDR_FEATURE) begin
         enReg <= wb_dat_i[SFS_FEAT_EN_BIT];
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   sequence taken;
      clkEn && wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence rdAt(logic [7:0] a);
      taken ##0 (!wb_we_i && wb_adr_i == a);
   endsequence
   AST_ACK_NEXT: assert property (taken |=> wb_ack_o)
      else $error("ack missing after request");
   AST_ACK_PULSE: assert property (wb_ack_o && clkEn |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   AST_CRC_RESET: assert property (clkEn && frameEnd |=> crcReset)
      else $error("crc reset missing after frame end");
   AST_CRC_CAUSE: assert property (crcReset && $past(clkEn) |->
      $past(frameEnd))
      else $error("crc reset without frame end");
   AST_FEAT_READ: assert property (rdAt(SFS_ADDR_FEATURE) |=>
      wb_dat_o[SFS_FEAT_EN_BIT] == enReg)
      else $error("enable readback wrong");
   AST_UPPER_ZERO: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
      else $error("upper read bits not zero");
   AST_MIRROR_EXT: assert property (rdAt(SFS_ADDR_EXT_IMAGE) |=>
      wb_dat_o[7:0] == $past(extStatus))
      else $error("ext status image wrong");
   AST_BYPASS: assert property (rdAt(SFS_ADDR_RX_COND) |=>
      wb_dat_o[0] == $past(rxAllSent) && wb_dat_o[4] == $past(rxParity)
      && wb_dat_o[7] == $past(rxEndOfFrame))
      else $error("bypass status bits wrong");
   AST_TOP_CLEAR: assert property (taken ##0 (wb_we_i && wb_sel_i[0]
      && wb_adr_i == SFS_ADDR_COMMAND && wb_dat_i[1]) |=> ##[0:1] topServiceClear)
      else $error("top clear pulse missing");
endmodule : sfs_frame_status_fifo_checker

// ### test/sfs_rx_model.sv
/*
 Receiver model: byte pulses, frame end or abort, and queued status levels.
 Assumes the caller enters send just after a rising edge of core_clk.
*/
`timescale 1ns/1ps
module sfs_rx_model (
   input  wire logic       core_clk,
   output logic            rxByteDone,
   output logic            frameEnd,
   output logic            frameAbort,
   output logic      [2:0] rxResidue,
   output logic            rxOverrun,
   output logic            rxCrcError
);
   // idle: no events, status cleared
   initial begin
      {rxByteDone, frameEnd, frameAbort} = 3'h0;
      {rxCrcError, rxOverrun, rxResidue} = 5'h00;
   end
   // status is set with the first byte so it is stable at the closing event
   task send(input int n, input logic [4:0] s, input logic ab);
      {rxCrcError, rxOverrun, rxResidue} <= s;
      rxByteDone <= 1'b1;
      repeat (n) @(posedge core_clk);
      rxByteDone <= 1'b0;
      frameEnd <= !ab;
      frameAbort <= ab;
      @(posedge core_clk);
      {frameEnd, frameAbort} <= 2'h0;
      @(posedge core_clk);
   endtask : send
endmodule : sfs_rx_model

// ### test/sfs_frame_status_fifo_tb.sv
/*
 Self-checking bench for the frame status queue over classic Wishbone.
 Assumes sfs_pkg, the design, the receiver model and the checker.
*/
`timescale 1ns/1ps
module sfs_frame_status_fifo_tb
   import sfs_pkg::*;
   ;
   logic core_clk = 1'b0, sys_rst = 1'b1, clkEn = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
   logic bitSyncMode = 1'b1, rxAllSent = 1'b0, rxParity = 1'b0;
   logic rxEndOfFrame = 1'b0, headCharEof = 1'b0, headCharErr = 1'b0;
   logic headCharRead = 1'b0, rxByteDone, frameEnd, frameAbort, rxOverrun;
   logic rxCrcError, crcReset, rxDataVectorIrq, specialRxIrq, rxFifoLocked;
   logic topServiceClear;
   logic [2:0] rxResidue;
   logic [7:0] extStatus = 8'h0, vectorValue = 8'h0, pendingValue = 8'h0;
   logic [31:0] expQ[$], mskQ[$];
   logic [13:0] cnt[10];
   logic [4:0] st[10], s;
   int seed = 69, failures = 0, checked = 0, nb;

   sfs_frame_status_fifo uut (.core_clk, .sys_rst, .clkEn, .wb_cyc_i,
      .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
      .wb_ack_o, .bitSyncMode, .rxByteDone, .frameEnd, .frameAbort,
      .rxResidue, .rxOverrun, .rxCrcError, .rxAllSent, .rxParity,
      .rxEndOfFrame, .extStatus, .vectorValue, .pendingValue,
      .headCharEof, .headCharErr, .headCharRead, .crcReset,
      .rxDataVectorIrq, .specialRxIrq, .rxFifoLocked, .topServiceClear);
   sfs_rx_model rx (.core_clk, .rxByteDone, .frameEnd, .frameAbort,
      .rxResidue, .rxOverrun, .rxCrcError);

   initial begin
      forever #2.5 core_clk = ~core_clk;
   end
   // -----------------------------------------------------------------
   // compare, verdict and bus tasks
   // -----------------------------------------------------------------
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : cmp
   task report_and_stop;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : report_and_stop
   // one classic cycle; a zero mask means the answer is not compared
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
            input logic [31:0] m);
      int k;
      expQ.push_back(d);
      mskQ.push_back(m);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i} <= {2'b11, w, a, 4'hf};
      wb_dat_i <= w ? d : $random(seed);
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 20);
      if (k >= 20) cmp(32'h1, 32'h0);
      if (k >= 20) report_and_stop;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
      @(posedge core_clk);
   endtask : bus
   // bounded wait for an interrupt or lock output to reach a level
   task waitOut(input int sel, input logic v);
      int k;
      logic o;
      k = 0;
      o = ~v;
      while (o !== v && k < 16) begin
         @(posedge core_clk);
         k++;
         o = sel == 0 ? rxDataVectorIrq : (sel == 1 ? specialRxIrq : rxFifoLocked);
      end
      cmp({31'h0, o}, {31'h0, v});
   endtask : waitOut
   function logic [7:0] cond(input logic [4:0] v);
      return {rxEndOfFrame, v[4], v[3], rxParity, v[2:0], rxAllSent};
   endfunction : cond
   // read answers are matched in issue order against the noted values
   always @(posedge core_clk) begin
      if (wb_ack_o === 1'b1) begin
         if (expQ.size() == 0) cmp(32'h1, 32'h0);
         else if (mskQ[0] != 0) cmp(wb_dat_o & mskQ[0], expQ[0] & mskQ[0]);
         void'(expQ.pop_front());
         void'(mskQ.pop_front());
      end
   end
   // -----------------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------------
   initial begin
      @(posedge core_clk);
      {extStatus, vectorValue, pendingValue} <= $random(seed);
      {rxAllSent, rxParity, rxEndOfFrame} <= $random(seed);
      @(posedge core_clk);
      sys_rst <= 1'b0;
      bus(0, SFS_ADDR_FEATURE, 32'h0, 32'h4);
      bus(0, SFS_ADDR_CNT_HIGH, {24'h0, pendingValue}, '1);
      bus(0, SFS_ADDR_EXT_IMAGE, {24'h0, extStatus}, '1);
      bus(0, 8'h80, 32'h0, '1);
      $display("test reset and mirrors done");
      bus(1, SFS_ADDR_FEATURE, 32'h4, 0);
      bus(0, SFS_ADDR_FEATURE, 32'h4, 32'h4);
      // frame 0 crosses the low count byte, frame 3 aborts, frame 10 overflows
      for (int i = 0; i < 11; i++) begin
         nb = i == 0 ? 300 : 1 + ({$random(seed)} % 20);
         s = $random(seed);
         if (i < 10) {cnt[i], st[i]} = {nb[13:0], s};
         rx.send(nb, s, i == 3);
      end
      for (int i = 0; i < 10; i++) begin
         bus(0, SFS_ADDR_CNT_HIGH, {24'h0, 2'b11, cnt[i][13:8]}, 32'hff);
         bus(0, SFS_ADDR_CNT_LOW, {24'h0, cnt[i][7:0]}, 32'hff);
         bus(0, SFS_ADDR_RX_COND, cond(st[i]), i == 3 ? 32'h91 : 32'hff);
      end
      bus(0, SFS_ADDR_CNT_HIGH, 32'h80, 32'hc0);
      bus(0, SFS_ADDR_RX_COND, cond(s), 32'hff);
      bus(0, SFS_ADDR_RX_COND_IMAGE, cond(s), 32'hff);
      bus(1, SFS_ADDR_FEATURE, 32'h0, 0);
      bus(1, SFS_ADDR_FEATURE, 32'h4, 0);
      bus(0, SFS_ADDR_CNT_HIGH, 32'h0, 32'hc0);
      bitSyncMode <= 1'b0;
      rx.send(5, 5'h0, 1'b0);
      bitSyncMode <= 1'b1;
      bus(0, SFS_ADDR_CNT_HIGH, 32'h0, 32'h40);
      // a frame end while the clock enable is low must not push
      clkEn <= 1'b0;
      rx.send(3, 5'h0, 1'b0);
      clkEn <= 1'b1;
      bus(0, SFS_ADDR_CNT_HIGH, 32'h0, 32'h40);
      $display("test queue order and overflow done");
      bus(1, SFS_ADDR_INT_MODE, 32'h18, 0);
      headCharEof <= 1'b1;
      waitOut(0, 1'b1);
      {headCharErr, headCharRead} <= 2'b11;
      @(posedge core_clk);
      {headCharErr, headCharRead} <= 2'b00;
      waitOut(1, 1'b1);
      waitOut(2, 1'b1);
      bus(1, SFS_ADDR_COMMAND, 32'h1, 0);
      waitOut(2, 1'b0);
      bus(1, SFS_ADDR_COMMAND, 32'h2, 0);
      // without the anti-lock mode a frame-end character locks the path
      bus(1, SFS_ADDR_INT_MODE, 32'h0, 0);
      headCharRead <= 1'b1;
      @(posedge core_clk);
      headCharRead <= 1'b0;
      waitOut(0, 1'b0);
      waitOut(2, 1'b1);
      bus(1, SFS_ADDR_COMMAND, 32'h1, 0);
      waitOut(2, 1'b0);
      $display("test interrupts done");
      sys_rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      sys_rst <= 1'b0;
      bus(0, SFS_ADDR_FEATURE, 32'h0, 32'h4);
      bus(0, SFS_ADDR_CNT_HIGH, {24'h0, pendingValue}, '1);
      $display("test mid-run reset done");
      report_and_stop;
   end
endmodule : sfs_frame_status_fifo_tb

bind sfs_frame_status_fifo sfs_frame_status_fifo_checker chk (.core_clk,
   .sys_rst, .clkEn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
   .wb_dat_i, .wb_dat_o, .wb_ack_o, .frameEnd, .crcReset, .extStatus,
   .rxAllSent, .rxParity, .rxEndOfFrame, .topServiceClear);
